// File: hdl/core_exec.sv
// execution unit for returns, rotates, subtract-with-borrow and skips
// assumes the sequencer holds i_op until o_busy drops and supplies
// the memory operand and stack top on the same cycle as the op
// Function
// - plain return loads pc from stack top, flags kept, two cycles.
// - return with literal restores pc and loads the 8-bit literal into acc.
// - rotate left through carry into memory; old carry to bit 0.
// - rotate right into memory, bit 0 to bit 7, no flag changes.
// - rotate right through carry into acc; old carry to bit 7.
// - subtract borrow: acc + ~m + c to acc or memory; ov z ac c set.
// - decrement memory; zero result discards next fetch with a dummy cycle.
// - decrement into acc, memory kept, skip with dummy cycle on zero.
`include "core_exec_params.svh"
`timescale 1ns/100ps
`default_nettype none
module core_exec import core_exec_pkg::*; #(
	parameter int PC_W = 13
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// instruction
	input wire logic i_valid,
	input wire exec_op_t i_op,
	input wire logic [7:0] i_literal,
	input wire logic [7:0] i_mem_rd,
	input wire logic [PC_W-1:0] i_stack_top,
	// results
	output logic o_busy,
	output logic [7:0] o_acc,
	output logic [3:0] o_flags,
	output logic o_global_interrupt_enable,
	output logic o_mem_we,
	output logic [7:0] o_mem_wd,
	output logic o_pc_load,
	output logic [PC_W-1:0] o_pc,
	output logic o_stack_pop,
	output logic o_discard_fetch
);
	// the stack port is at most 16 bits wide
	if (PC_W < 1 || PC_W > 16) begin : g_bad_pc_w
		$error("PC_W out of range");
	end
	// ============================================================
	// reset release
	logic rst_s1_q, rst_n_q;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end
	// ============================================================
	// datapath
	logic [7:0] acc_q, acc_d, wd_q, wd_d;
	logic [3:0] flags_q, flags_d;
	logic gie_q, gie_d, we_q, we_d, pcl_q, pcl_d, pop_q, pop_d;
	logic disc_q, disc_d;
	logic [PC_W-1:0] pc_q, pc_d;
	exec_state_t st_q, st_d;
	logic [8:0] sum;
	logic [4:0] lo;
	logic [7:0] dec, nm;
	logic c;
	always_comb begin
		c = flags_q[`FLAG_C];
		nm = ~i_mem_rd;
		sum = {1'b0, acc_q} + {1'b0, nm} + {8'h00, c};
		lo = {1'b0, acc_q[3:0]} + {1'b0, nm[3:0]} + {4'h0, c};
		dec = i_mem_rd - 8'h01;
		acc_d = acc_q;
		wd_d = wd_q;
		flags_d = flags_q;
		gie_d = gie_q;
		we_d = 1'b0;
		pcl_d = 1'b0;
		pop_d = 1'b0;
		disc_d = 1'b0;
		pc_d = pc_q;
		st_d = ST_READY;
		unique case (st_q)
		ST_READY: begin
			if (i_valid) begin
				unique case (i_op)
				OP_PLAIN_RETURN, OP_RETURN_WITH_LITERAL,
				OP_INTERRUPT_RETURN: begin
					pc_d = i_stack_top;
					pcl_d = 1'b1;
					pop_d = 1'b1;
					st_d = ST_SECOND;
					if (i_op == OP_RETURN_WITH_LITERAL)
						acc_d = i_literal;
					if (i_op == OP_INTERRUPT_RETURN)
						gie_d = 1'b1;
				end
				OP_ROTATE_LEFT: begin
					wd_d = {i_mem_rd[6:0], i_mem_rd[7]};
					we_d = 1'b1;
				end
				OP_ROTATE_LEFT_TO_ACC:
					acc_d = {i_mem_rd[6:0], i_mem_rd[7]};
				OP_ROTATE_LEFT_CARRY: begin
					wd_d = {i_mem_rd[6:0], c};
					we_d = 1'b1;
					flags_d[`FLAG_C] = i_mem_rd[7];
				end
				OP_ROTATE_LEFT_CARRY_TO_ACC: begin
					acc_d = {i_mem_rd[6:0], c};
					flags_d[`FLAG_C] = i_mem_rd[7];
				end
				OP_ROTATE_RIGHT: begin
					wd_d = {i_mem_rd[0], i_mem_rd[7:1]};
					we_d = 1'b1;
				end
				OP_ROTATE_RIGHT_TO_ACC:
					acc_d = {i_mem_rd[0], i_mem_rd[7:1]};
				OP_ROTATE_RIGHT_CARRY: begin
					wd_d = {c, i_mem_rd[7:1]};
					we_d = 1'b1;
					flags_d[`FLAG_C] = i_mem_rd[0];
				end
				OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
					acc_d = {c, i_mem_rd[7:1]};
					flags_d[`FLAG_C] = i_mem_rd[0];
				end
				OP_SUBTRACT_BORROW_TO_ACC, OP_SUBTRACT_BORROW_TO_MEMORY: begin
					if (i_op == OP_SUBTRACT_BORROW_TO_ACC)
						acc_d = sum[7:0];
					else begin
						wd_d = sum[7:0];
						we_d = 1'b1;
					end
					flags_d[`FLAG_C] = sum[8];
					flags_d[`FLAG_AC] = lo[4];
					flags_d[`FLAG_Z] = (sum[7:0] == 8'h00);
					// overflow: like-signed operands, differing result sign
					flags_d[`FLAG_OV] = (acc_q[7] == nm[7]) &&
						(sum[7] != acc_q[7]);
				end
				OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO_TO_ACC: begin
					// flags are left alone even on a zero result
					if (i_op == OP_DECREMENT_SKIP_ZERO) begin
						wd_d = dec;
						we_d = 1'b1;
					end else
						acc_d = dec;
					if (dec == 8'h00) begin
						disc_d = 1'b1;
						st_d = ST_SECOND;
					end
				end
				default: ;
				endcase
			end
		end
		ST_SECOND: st_d = ST_READY;
		default: st_d = ST_READY;
		endcase
	end
	always_ff @(posedge i_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			acc_q <= `ACC_RST;
			wd_q <= `WD_RST;
			flags_q <= `FLAGS_RST;
			gie_q <= 1'b0;
			we_q <= 1'b0;
			pcl_q <= 1'b0;
			pop_q <= 1'b0;
			disc_q <= 1'b0;
			pc_q <= '0;
			st_q <= ST_READY;
		end else begin
			acc_q <= acc_d;
			wd_q <= wd_d;
			flags_q <= flags_d;
			gie_q <= gie_d;
			we_q <= we_d;
			pcl_q <= pcl_d;
			pop_q <= pop_d;
			disc_q <= disc_d;
			pc_q <= pc_d;
			st_q <= st_d;
		end
	end
	// busy covers the dummy/second cycle so the sequencer stalls
	assign o_busy = (st_q == ST_SECOND);
	assign o_acc = acc_q;
	assign o_flags = flags_q;
	assign o_global_interrupt_enable = gie_q;
	assign o_mem_we = we_q;
	assign o_mem_wd = wd_q;
	assign o_pc_load = pcl_q;
	assign o_pc = pc_q;
	assign o_stack_pop = pop_q;
	assign o_discard_fetch = disc_q;
	// ============================================================
	// checks
	AST_RET_TWO: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(i_valid && st_q == ST_READY && i_op == OP_PLAIN_RETURN) |=>
		o_pc_load && o_busy && o_pc == $past(i_stack_top) &&
		$stable(o_flags) ##1 !o_busy)
		else $error("plain return timing wrong");
	AST_RET_LIT: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(i_valid && st_q == ST_READY && i_op == OP_RETURN_WITH_LITERAL) |=>
		o_acc == $past(i_literal) && $stable(o_flags))
		else $error("literal not loaded");
	AST_INTERRUPT_RETURN: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(i_valid && st_q == ST_READY && i_op == OP_INTERRUPT_RETURN) |=>
		o_global_interrupt_enable && o_pc_load)
		else $error("interrupt enable not set");
	AST_RLC: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(i_valid && st_q == ST_READY && i_op == OP_ROTATE_LEFT_CARRY) |=>
		o_mem_we && o_mem_wd == {$past(i_mem_rd[6:0]), $past(c)} &&
		o_flags[`FLAG_C] == $past(i_mem_rd[7]))
		else $error("rotate left carry wrong");
	AST_ROTATE_LEFT_CARRY_TO_ACC: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(i_valid && st_q == ST_READY && i_op == OP_ROTATE_LEFT_CARRY_TO_ACC)
		|=> !o_mem_we && o_acc == {$past(i_mem_rd[6:0]), $past(c)})
		else $error("rotate left carry to acc wrong");
	AST_RR: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(i_valid && st_q == ST_READY && i_op == OP_ROTATE_RIGHT) |=>
		o_mem_wd == {$past(i_mem_rd[0]), $past(i_mem_rd[7:1])} &&
		$stable(o_flags))
		else $error("rotate right wrong");
	AST_ROTATE_RIGHT_CARRY_TO_ACC: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(i_valid && st_q == ST_READY && i_op == OP_ROTATE_RIGHT_CARRY_TO_ACC)
		|=> o_acc[7] == $past(c) && o_flags[`FLAG_C] == $past(i_mem_rd[0]))
		else $error("rotate right carry to acc wrong");
	AST_SBC: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(i_valid && st_q == ST_READY && i_op == OP_SUBTRACT_BORROW_TO_ACC) |=>
		{o_flags[`FLAG_C], o_acc} == {1'b0, $past(o_acc)} +
		{1'b0, ~$past(i_mem_rd)} + {8'h00, $past(o_flags[`FLAG_C])} &&
		o_flags[`FLAG_Z] == (o_acc == 8'h00))
		else $error("subtract borrow wrong");
	AST_SDZ: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(i_valid && st_q == ST_READY && i_op == OP_DECREMENT_SKIP_ZERO &&
		i_mem_rd == 8'h01) |=> o_discard_fetch && o_busy && o_mem_we
		##1 !o_busy)
		else $error("skip not taken");
	AST_DECREMENT_SKIP_ZERO_TO_ACC: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(i_valid && st_q == ST_READY && i_op == OP_DECREMENT_SKIP_ZERO_TO_ACC
		&& i_mem_rd != 8'h01) |=> !o_discard_fetch && !o_busy && !o_mem_we)
		else $error("false skip");
	AST_RL: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(i_valid && st_q == ST_READY && i_op == OP_ROTATE_LEFT) |=>
		o_mem_wd == {$past(i_mem_rd[6:0]), $past(i_mem_rd[7])} &&
		$stable(o_flags))
		else $error("rotate left wrong");
	AST_SKIP_FLAGS: assert property (@(posedge i_clk) disable iff (!rst_n_q)
		(i_valid && st_q == ST_READY && (i_op == OP_DECREMENT_SKIP_ZERO ||
		i_op == OP_DECREMENT_SKIP_ZERO_TO_ACC)) |=> $stable(o_flags))
		else $error("skip changed flags");
endmodule // core_exec
`default_nettype wire

// File: shared/core_exec_params.svh
// constants for the return/rotate/subtract/skip execution block
// assumes inclusion by bare name from the design
`ifndef CORE_EXEC_PARAMS_SVH
`define CORE_EXEC_PARAMS_SVH
`define RET_CYCLES 2'h2
`define SKIP_CYCLES 2'h2
`define PLAIN_CYCLES 2'h1
`define ACC_RST 8'h00
`define CARRY_RST 1'b0
`define FLAGS_RST 4'h0
`define WD_RST 8'h00
`define FLAG_C 0
`define FLAG_AC 1
`define FLAG_Z 2
`define FLAG_OV 3
`endif

// File: shared/core_exec_pkg.sv
// types for the return/rotate/subtract/skip execution block
// assumes nothing beyond the params header
package core_exec_pkg;
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_PLAIN_RETURN = 4'h1,
		OP_RETURN_WITH_LITERAL = 4'h2,
		OP_INTERRUPT_RETURN = 4'h3,
		OP_ROTATE_LEFT = 4'h4,
		OP_ROTATE_LEFT_TO_ACC = 4'h5,
		OP_ROTATE_LEFT_CARRY = 4'h6,
		OP_ROTATE_LEFT_CARRY_TO_ACC = 4'h7,
		OP_ROTATE_RIGHT = 4'h8,
		OP_ROTATE_RIGHT_TO_ACC = 4'h9,
		OP_ROTATE_RIGHT_CARRY = 4'ha,
		OP_ROTATE_RIGHT_CARRY_TO_ACC = 4'hb,
		OP_SUBTRACT_BORROW_TO_ACC = 4'hc,
		OP_SUBTRACT_BORROW_TO_MEMORY = 4'hd,
		OP_DECREMENT_SKIP_ZERO = 4'he,
		OP_DECREMENT_SKIP_ZERO_TO_ACC = 4'hf
	} exec_op_t;
	typedef enum logic [1:0] {
		ST_READY = 2'b00,
		ST_SECOND = 2'b01
	} exec_state_t;
endpackage

// File: verif/core_exec_tb.sv
// bench: reference model of the execution block, checked per result
// assumes core_exec and exec_partner are compiled first
`timescale 1ns/100ps
`default_nettype none
module core_exec_tb import core_exec_pkg::*;;
	logic i_clk = 0, i_arst_n = 0, i_valid = 0, ld = 0, psh = 0;
	exec_op_t i_op = OP_NONE;
	logic [7:0] i_literal = 8'h00, ld_d = 8'h00, mrd, acc = 0, o_acc, o_wd;
	logic [12:0] psh_d = 0, top, o_pc;
	logic [3:0] fl = 0, o_flags;
	logic gie = 0, o_gie, o_busy, o_we, o_pl, o_pop, o_disc;
	int num_errors = 0, comparisons = 0, cyc = 0;
	core_exec u_core_exec (.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_valid(i_valid), .i_op(i_op), .i_literal(i_literal),
		.i_mem_rd(mrd), .i_stack_top(top), .o_busy(o_busy), .o_acc(o_acc),
		.o_flags(o_flags), .o_global_interrupt_enable(o_gie),
		.o_mem_we(o_we), .o_mem_wd(o_wd), .o_pc_load(o_pl), .o_pc(o_pc),
		.o_stack_pop(o_pop), .o_discard_fetch(o_disc));
	exec_partner u_exec_partner (.i_clk(i_clk), .i_load(ld),
		.i_load_data(ld_d), .i_push(psh), .i_push_data(psh_d),
		.i_mem_we(o_we), .i_mem_wd(o_wd), .i_stack_pop(o_pop),
		.o_mem_rd(mrd), .o_stack_top(top));
	initial forever #4 i_clk = ~i_clk;
	// ==========
	// checking
	task automatic chk(input string nm, input logic [15:0] e, g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		// run needs about 220 cycles
		if (cyc == 2000) begin
			num_errors++;
			stop_test();
		end
	end
	// ==========
	// one instruction through model and design
	task automatic run(input exec_op_t op, input logic [7:0] m);
		logic [8:0] s;
		logic [7:0] r, lit;
		logic [12:0] pc;
		logic c, we, ret, skp;
		pc = 13'($urandom);
		lit = 8'($urandom);
		c = fl[0];
		r = m;
		{we, ret, skp} = 3'b000;
		case (op)
			OP_PLAIN_RETURN: ret = 1;
			OP_RETURN_WITH_LITERAL: {ret, acc} = {1'b1, lit};
			OP_INTERRUPT_RETURN: {ret, gie} = 2'b11;
			OP_ROTATE_LEFT: {we, r} = {1'b1, m[6:0], m[7]};
			OP_ROTATE_LEFT_TO_ACC: acc = {m[6:0], m[7]};
			OP_ROTATE_LEFT_CARRY: {we, r, fl[0]} = {1'b1, m[6:0], c, m[7]};
			OP_ROTATE_LEFT_CARRY_TO_ACC: {acc, fl[0]} = {m[6:0], c, m[7]};
			OP_ROTATE_RIGHT: {we, r} = {1'b1, m[0], m[7:1]};
			OP_ROTATE_RIGHT_TO_ACC: acc = {m[0], m[7:1]};
			OP_ROTATE_RIGHT_CARRY: {we, r, fl[0]} = {1'b1, c, m[7:1], m[0]};
			OP_ROTATE_RIGHT_CARRY_TO_ACC: {acc, fl[0]} = {c, m[7:1], m[0]};
			OP_DECREMENT_SKIP_ZERO: begin
				{we, r} = {1'b1, m - 8'h01};
				skp = (r == 8'h00);
			end
			OP_DECREMENT_SKIP_ZERO_TO_ACC: begin
				acc = m - 8'h01;
				skp = (acc == 8'h00);
			end
			default: begin
				s = {1'b0, acc} + {1'b0, ~m} + {8'h00, c};
				r = s[7:0];
				fl = {(acc[7] == ~m[7]) && (r[7] != acc[7]), r == 8'h00,
					({1'b0, acc[3:0]} + {1'b0, ~m[3:0]} + {4'h0, c}) > 5'h0f, s[8]};
				if (op == OP_SUBTRACT_BORROW_TO_ACC) acc = r;
				else we = 1;
			end
		endcase
		@(negedge i_clk);
		{ld, ld_d, psh, psh_d} = {1'b1, m, 1'b1, pc};
		@(negedge i_clk);
		{ld, psh, i_valid, i_op, i_literal} = {1'b0, 1'b0, 1'b1, op, lit};
		@(negedge i_clk);
		// a request during the second cycle must be ignored
		i_valid = ret | skp;
		chk("acc", acc, o_acc);
		chk("flags", fl, o_flags);
		chk("gie", gie, o_gie);
		chk("mem_we", we, o_we);
		if (we) chk("mem_wd", r, o_wd);
		chk("pc_load", {ret, ret}, {o_pl, o_pop});
		if (ret) chk("pc", pc, o_pc);
		chk("discard", skp, o_disc);
		chk("busy", ret | skp, o_busy);
		if (ret | skp) begin
			@(negedge i_clk);
			i_valid = 0;
			chk("busy_end", 0, o_busy);
			chk("refused", 0, {o_pl, o_we, o_disc});
			chk("acc_held", acc, o_acc);
		end
	endtask
	// ==========
	// main sequence
	initial begin
		void'($urandom(32'h955b));
		repeat (20) @(negedge i_clk);
		i_arst_n = 1;
		repeat (4) @(negedge i_clk);
		// pass 0 hits the skip, pass 1 the wrap from zero
		for (int p = 0; p < 4; p++) begin
			for (int k = 1; k < 16; k++)
				run(exec_op_t'(k), p == 0 ? 8'h01 : p == 1 ? 8'h00 : 8'($urandom));
			$display("test %0d done", p);
		end
		stop_test();
	end
endmodule // core_exec_tb
`default_nettype wire

// File: verif/exec_partner.sv
// partner: one data memory byte and an eight-deep program stack
// assumes the bench preloads memory and pushes return addresses
`timescale 1ns/100ps
`default_nettype none
module exec_partner #(
	parameter int PC_W = 13
) (
	input wire logic i_clk,
	input wire logic i_load,
	input wire logic [7:0] i_load_data,
	input wire logic i_push,
	input wire logic [PC_W-1:0] i_push_data,
	input wire logic i_mem_we,
	input wire logic [7:0] i_mem_wd,
	input wire logic i_stack_pop,
	output logic [7:0] o_mem_rd,
	output logic [PC_W-1:0] o_stack_top
);
	logic [PC_W-1:0] stack_q [8];
	logic [2:0] sp_q = 3'h0;
	logic [7:0] mem_q = 8'h00;
	always @(posedge i_clk) begin
		if (i_load) mem_q <= i_load_data;
		else if (i_mem_we) mem_q <= i_mem_wd;
		if (i_push) begin
			stack_q[sp_q] <= i_push_data;
			sp_q <= sp_q + 3'h1;
		end else if (i_stack_pop) sp_q <= sp_q - 3'h1;
	end
	assign o_mem_rd = mem_q;
	// stack wraps like the real one: no overflow flag
	assign o_stack_top = stack_q[sp_q - 3'h1];
endmodule // exec_partner
`default_nettype wire
